// ==== src/lsd_pkg.sv ====
/*
  Constants, types and the segment decode function shared by the six-digit LCD
  seven-segment driver.
  Assumes a single 20 MHz system clock and segment bits ordered {g,f,e,d,c,b,a}.
*/
// Behaviour
// - first strobe edge captures byte one, held
// - byte one drives two least significant digits
// - strobes two, three capture bytes two, three
// - lit segment driven inverted from backplane
// - unlit segment driven in phase with backplane
// - backplane is continuous low-frequency oscillator square wave
// - backplane high and low times equal
// - backplane runs at about eighty hertz
// - six digits, each own register and decoder
// - decode is hexadecimal or BCD, fixed at build
// - bit zero least significant, standard hex table
package lsd_pkg;
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned BP_FREQ_HZ    = 80;
  // half period in cycles; rounded down so the rate never falls below target
  localparam int unsigned BP_HALF_CYC   = CLK_HZ / (2 * BP_FREQ_HZ);
  localparam int unsigned BP_CNT_W      = 24;
  localparam int unsigned NUM_BYTES     = 3;
  localparam int unsigned NUM_DIGITS    = 6;
  localparam int unsigned DIGIT_W       = 4;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned SEG_W         = 7;
  localparam int unsigned DIGIT_BIT_LSB = 0;
  localparam int unsigned DIGIT_BIT_MSB = 3;
  localparam logic [3:0]  DIGIT_RESET   = 4'h0;
  localparam logic [6:0]  SEG_BLANK     = 7'h00;
  localparam logic [3:0]  BCD_MAX       = 4'h9;

  typedef logic [DIGIT_W-1:0] lsd_digit_t;
  typedef logic [SEG_W-1:0]   lsd_seg_t;

  // returns lit segments, one per bit, {g,f,e,d,c,b,a}
  function automatic lsd_seg_t lsd_decode(input lsd_digit_t val, input logic bcd);
    lsd_seg_t s;
    s = SEG_BLANK;
    case (val)
      4'h0: s = 7'h3F;
      4'h1: s = 7'h06;
      4'h2: s = 7'h5B;
      4'h3: s = 7'h4F;
      4'h4: s = 7'h66;
      4'h5: s = 7'h6D;
      4'h6: s = 7'h7D;
      4'h7: s = 7'h07;
      4'h8: s = 7'h7F;
      4'h9: s = 7'h6F;
      4'hA: s = 7'h77;
      4'hB: s = 7'h7C;
      4'hC: s = 7'h39;
      4'hD: s = 7'h5E;
      4'hE: s = 7'h79;
      4'hF: s = 7'h71;
      default: s = SEG_BLANK;
    endcase
    // BCD build blanks the non-decimal codes rather than showing letters
    if (bcd && (val > BCD_MAX)) begin
      s = SEG_BLANK;
    end
    return s;
  endfunction
endpackage

// ==== src/lsd_driver.sv ====
/*
  Six-digit seven-segment LCD driver: three strobed input bytes, per-digit
  registers and decoders, backplane square wave and XOR phase control.
  Assumes strobes and bytes come from pins (asynchronous to clk) and that each
  byte is stable from before its strobe rises until two clocks after.
*/
`timescale 1ns/10ps
module lsd_driver
  import lsd_pkg::*;
#(
  parameter int unsigned HALF_CYC   = BP_HALF_CYC,
  parameter bit          DECODE_BCD = 1'b0
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic                          load_strobe_a,
  input  wire logic                          load_strobe_b,
  input  wire logic                          load_strobe_c,
  input  wire logic [BYTE_W-1:0]             byte_a,
  input  wire logic [BYTE_W-1:0]             byte_b,
  input  wire logic [BYTE_W-1:0]             byte_c,
  output logic                               backplane,
  output logic [NUM_DIGITS*SEG_W-1:0]        seg_drive
);

  localparam int unsigned DATA_W = NUM_BYTES * BYTE_W;
  localparam logic [BP_CNT_W-1:0] BP_LAST = BP_CNT_W'(HALF_CYC - 1);

  // input synchronisers: strobes get a third stage for edge detection
  logic [NUM_BYTES-1:0] strb_s1;
  logic [NUM_BYTES-1:0] strb_s2;
  logic [NUM_BYTES-1:0] strb_s3;
  logic [DATA_W-1:0]    data_s1;
  logic [DATA_W-1:0]    data_s2;
  logic [NUM_BYTES-1:0] next_strb_s1;
  logic [NUM_BYTES-1:0] next_strb_s2;
  logic [NUM_BYTES-1:0] next_strb_s3;
  logic [DATA_W-1:0]    next_data_s1;
  logic [DATA_W-1:0]    next_data_s2;
  logic [NUM_BYTES-1:0] strb_rise;

  always_comb begin
    next_strb_s1 = {load_strobe_c, load_strobe_b, load_strobe_a};
    next_strb_s2 = strb_s1;
    next_strb_s3 = strb_s2;
    next_data_s1 = {byte_c, byte_b, byte_a};
    next_data_s2 = data_s1;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      strb_s1 <= '0;
      strb_s2 <= '0;
      strb_s3 <= '0;
      data_s1 <= '0;
      data_s2 <= '0;
    end else begin
      strb_s1 <= next_strb_s1;
      strb_s2 <= next_strb_s2;
      strb_s3 <= next_strb_s3;
      data_s1 <= next_data_s1;
      data_s2 <= next_data_s2;
    end
  end

  // data stage two lines up with strobe stage two, so the byte is sampled
  // in the same cycle the rising edge is seen
  assign strb_rise = strb_s2 & ~strb_s3;

  // digit registers: digit 2k is the low nibble of byte k, 2k+1 the high
  lsd_digit_t digit      [NUM_DIGITS];
  lsd_digit_t next_digit [NUM_DIGITS];
  lsd_seg_t   lit        [NUM_DIGITS];
  logic [NUM_DIGITS*SEG_W-1:0] lit_flat;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIGITS; gi++) begin : g_digit
      localparam int unsigned BYTE_IX = gi / 2;
      localparam int unsigned LO_BIT  = BYTE_IX * BYTE_W + (gi % 2) * DIGIT_W;

      always_comb begin
        next_digit[gi] = digit[gi];
        if (strb_rise[BYTE_IX]) begin
          // bit DIGIT_BIT_LSB of the nibble is the least significant
          next_digit[gi] = data_s2[LO_BIT + DIGIT_BIT_MSB -: DIGIT_W];
        end
      end

      always_ff @(posedge clk) begin
        if (!nrst) begin
          digit[gi] <= DIGIT_RESET;
        end else begin
          digit[gi] <= next_digit[gi];
        end
      end

      always_comb begin
        lit[gi] = lsd_decode(digit[gi], DECODE_BCD);
      end

      // byte one lands on digits 0 and 1, the least significant pair
      assign lit_flat[gi*SEG_W +: SEG_W] = lit[gi];
    end
  endgenerate

  // backplane divider; a dc level across the glass would damage it, hence
  // a strict square wave with no gaps
  logic [BP_CNT_W-1:0]         bp_cnt;
  logic [BP_CNT_W-1:0]         next_bp_cnt;
  logic                        next_backplane;
  logic [NUM_DIGITS*SEG_W-1:0] next_seg_drive;

  always_comb begin
    next_bp_cnt    = bp_cnt + BP_CNT_W'(1);
    next_backplane = backplane;
    if (bp_cnt == BP_LAST) begin
      next_bp_cnt    = '0;
      next_backplane = ~backplane;
    end
    // segments flip with the backplane in the same cycle, so the phase is exact
    next_seg_drive = {(NUM_DIGITS*SEG_W){next_backplane}} ^ lit_flat;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      bp_cnt    <= '0;
      backplane <= 1'b0;
      seg_drive <= '0;
    end else begin
      bp_cnt    <= next_bp_cnt;
      backplane <= next_backplane;
      seg_drive <= next_seg_drive;
    end
  end

  // checks

  chk_capture_a_byte: assert property (@(posedge clk) disable iff (!nrst)
    strb_rise[0] |=> (digit[0] == $past(data_s2[3:0])) && (digit[1] == $past(data_s2[7:4])))
    else $error("byte one not captured into digits 0 and 1");

  chk_hold_a_byte: assert property (@(posedge clk) disable iff (!nrst)
    !strb_rise[0] |=> $stable(digit[0]) && $stable(digit[1]))
    else $error("digits 0 and 1 changed without a strobe edge");

  chk_capture_bc_bytes: assert property (@(posedge clk) disable iff (!nrst)
    (strb_rise[1] |=> (digit[2] == $past(data_s2[11:8])) && (digit[3] == $past(data_s2[15:12])))
    and (strb_rise[2] |=> (digit[4] == $past(data_s2[19:16]))
                          && (digit[5] == $past(data_s2[23:20]))))
    else $error("byte two or three not captured into its digit pair");

  chk_seg_phase: assert property (@(posedge clk) disable iff (!nrst)
    nrst[*2] |-> seg_drive == ({(NUM_DIGITS*SEG_W){backplane}} ^ $past(lit_flat)))
    else $error("segment phase does not follow backplane and decode");

  chk_bp_even_half: assert property (@(posedge clk) disable iff (!nrst)
    $changed(backplane) && $past(nrst) |-> $past(bp_cnt) == BP_LAST)
    else $error("backplane toggled at wrong count");

  chk_bp_keeps_running: assert property (@(posedge clk) disable iff (!nrst)
    (bp_cnt == BP_LAST) |=> (bp_cnt == '0) && (backplane != $past(backplane)))
    else $error("backplane did not toggle at end of half period");

  chk_reset_zero: assert property (@(posedge clk)
    !nrst |=> (digit[0] == DIGIT_RESET) && (digit[5] == DIGIT_RESET) && (seg_drive == '0))
    else $error("reset did not clear digits and outputs");

  chk_decode_zero: assert property (@(posedge clk) disable iff (!nrst)
    (digit[0] == 4'h0) |-> lit[0] == 7'h3F)
    else $error("zero does not light every segment but g");

  chk_bcd_blank: assert property (@(posedge clk) disable iff (!nrst)
    (DECODE_BCD && (digit[1] > BCD_MAX)) |-> lit[1] == SEG_BLANK)
    else $error("bcd build shows a non-decimal code");

  chk_bp_reset_low: assert property (@(posedge clk)
    !nrst |=> !backplane && (bp_cnt == '0))
    else $error("reset did not park the backplane low");

  chk_bp_cnt_bound: assert property (@(posedge clk) disable iff (!nrst)
    bp_cnt <= BP_LAST)
    else $error("backplane divider ran past its last count");

  chk_data_sync: assert property (@(posedge clk) disable iff (!nrst)
    nrst[*2] |-> (data_s2 == $past(data_s1)) && (strb_s3 == $past(strb_s2)))
    else $error("synchroniser stage skipped");

  // second count of the level length, kept apart from the divider so that a
  // divider fault cannot hide itself from the check below
  logic [BP_CNT_W-1:0] lvl_cnt;
  logic [BP_CNT_W-1:0] next_lvl_cnt;

  always_comb begin
    next_lvl_cnt = lvl_cnt + BP_CNT_W'(1);
    if (next_backplane != backplane) begin
      next_lvl_cnt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      lvl_cnt <= '0;
    end else begin
      lvl_cnt <= next_lvl_cnt;
    end
  end

  chk_bp_level_len: assert property (@(posedge clk) disable iff (!nrst)
    $changed(backplane) && $past(nrst) |-> $past(lvl_cnt) == BP_LAST)
    else $error("backplane level did not last one half period");

  chk_bp_level_max: assert property (@(posedge clk) disable iff (!nrst)
    lvl_cnt <= BP_LAST)
    else $error("backplane stopped toggling");

  genvar ci;
  generate
    for (ci = 0; ci < NUM_BYTES; ci++) begin : g_chk_strb
      chk_rise_once: assert property (@(posedge clk) disable iff (!nrst)
        strb_rise[ci] |=> !strb_rise[ci])
        else $error("one strobe edge loaded twice");

      chk_rise_source: assert property (@(posedge clk) disable iff (!nrst)
        nrst[*2] && strb_rise[ci] |-> $past(strb_s1[ci]) && !$past(strb_s2[ci]))
        else $error("load taken without a rising strobe");
    end

    for (ci = 0; ci < NUM_DIGITS; ci++) begin : g_chk_digit
      localparam int unsigned CHK_BYTE = ci / 2;

      chk_digit_hold: assert property (@(posedge clk) disable iff (!nrst)
        !strb_rise[CHK_BYTE] |=> $stable(digit[ci]))
        else $error("digit changed without its own strobe edge");

      chk_decode_eight: assert property (@(posedge clk) disable iff (!nrst)
        (digit[ci] == 4'h8) |-> lit[ci] == 7'h7F)
        else $error("eight does not light every segment");

      chk_decode_one: assert property (@(posedge clk) disable iff (!nrst)
        (digit[ci] == 4'h1) |-> lit[ci] == 7'h06)
        else $error("one does not light segments b and c only");

      chk_unlit_phase: assert property (@(posedge clk) disable iff (!nrst)
        nrst[*2] && ($past(lit[ci]) == SEG_BLANK)
        |-> seg_drive[ci*SEG_W +: SEG_W] == {SEG_W{backplane}})
        else $error("blank digit not in phase with backplane");

      chk_lit_phase: assert property (@(posedge clk) disable iff (!nrst)
        nrst[*2] && ($past(digit[ci]) == 4'h8)
        |-> seg_drive[ci*SEG_W +: SEG_W] == ~{SEG_W{backplane}})
        else $error("lit digit not inverted from backplane");
    end
  endgenerate

endmodule

// ==== tb/lsd_host.sv ====
/*
  Host model for the segment driver: presents a byte, raises the chosen strobes,
  then lets the byte lines go and signals completion.
  Assumes go is sampled on rising clk and is held low until done has pulsed.
*/
`timescale 1ns/10ps
module lsd_host
  import lsd_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic [2:0]            go,
  input  wire logic [BYTE_W-1:0]     val,
  output logic      [2:0]            strobe,
  output logic      [2:0][BYTE_W-1:0] data,
  output logic                       done
);
  logic [2:0]        g;
  logic [BYTE_W-1:0] v;
  // one process owns every output, so each has a single driver
  initial begin
    strobe = 3'h0;
    data = {3{8'hA5}};
    done = 1'b0;
    forever begin
      @(posedge clk);
      if (go != 3'h0) begin
        g = go;
        v = val;
        @(negedge clk);
        for (int i = 0; i < 3; i++) if (g[i]) data[i] = v;
        @(negedge clk);
        strobe = g;
        repeat (3) @(negedge clk);
        strobe = 3'h0;
        @(negedge clk);
        // released lines show the inverse, so a late capture cannot pass
        for (int i = 0; i < 3; i++) if (g[i]) data[i] = ~v;
        repeat (3) @(negedge clk);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
      end
    end
  end
endmodule

// ==== tb/lsd_driver_tb.sv ====
/*
  Self-checking bench: a hex and a bcd driver share one host model.
  Assumes seg_drive is backplane xor lit, so lit = seg_drive ^ backplane.
*/
`timescale 1ns/10ps
module lsd_driver_tb;
  import lsd_pkg::*;
  localparam int HC = 4;
  localparam logic [6:0] HEX [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D,
    7'h07, 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] go = 3'h0;
  logic [7:0] val = 8'h00;
  logic peek = 1'b0;
  logic [2:0] strobe;
  logic [2:0][7:0] data;
  logic done, bp, bp_b, bp_l, bp_seen;
  logic [41:0] seg, seg_b;
  logic [3:0] dig [6];
  logic [41:0] q_hex [$];
  logic [41:0] q_bcd [$];
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int run = 0;
  always #25 clk = ~clk;
  lsd_host host (.clk(clk), .go(go), .val(val), .strobe(strobe), .data(data), .done(done));
  lsd_driver #(.HALF_CYC(HC), .DECODE_BCD(1'b0)) dut (.clk(clk), .nrst(nrst),
    .load_strobe_a(strobe[0]), .load_strobe_b(strobe[1]), .load_strobe_c(strobe[2]),
    .byte_a(data[0]), .byte_b(data[1]), .byte_c(data[2]), .backplane(bp), .seg_drive(seg));
  lsd_driver #(.HALF_CYC(HC), .DECODE_BCD(1'b1)) dut_bcd (.clk(clk), .nrst(nrst),
    .load_strobe_a(strobe[0]), .load_strobe_b(strobe[1]), .load_strobe_c(strobe[2]),
    .byte_a(data[0]), .byte_b(data[1]), .byte_c(data[2]), .backplane(bp_b),
    .seg_drive(seg_b));
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp_seg(input logic [41:0] got, input logic [41:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: lit %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bp(input int n);
    num_checks++;
    if (n != HC) begin
      err_total++;
      $display("Error %0t: backplane level lasted %0d", $time, n);
    end
  endtask
  task automatic cmp_lvl(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: bcd backplane %b expected %b", $time, got, exp);
    end
  endtask
  task automatic note(input logic [2:0] m, input logic [7:0] v);
    logic [41:0] eh, eb;
    for (int i = 0; i < 3; i++) if (m[i]) {dig[2*i+1], dig[2*i]} = v;
    for (int d = 0; d < 6; d++) begin
      eh[7*d +: 7] = HEX[dig[d]];
      eb[7*d +: 7] = (dig[d] > 4'h9) ? 7'h00 : HEX[dig[d]];
    end
    q_hex.push_back(eh);
    q_bcd.push_back(eb);
  endtask
  task automatic load(input logic [2:0] m, input logic [7:0] v);
    note(m, v);
    @(negedge clk);
    go = m;
    val = v;
    @(negedge clk);
    go = 3'h0;
    for (int i = 0; i < 40 && done !== 1'b1; i++) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic reset_peek();
    for (int d = 0; d < 6; d++) dig[d] = 4'h0;
    note(3'h0, 8'h00);
    repeat (2) @(negedge clk);
    peek = 1'b1;
    @(negedge clk);
    peek = 1'b0;
  endtask
  always @(posedge clk) begin
    if (done === 1'b1 || peek === 1'b1) begin
      cmp_seg(seg ^ {42{bp}}, q_hex.pop_front());
      cmp_seg(seg_b ^ {42{bp_b}}, q_bcd.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      $display("Error %0t: run did not finish", $time);
      close_out();
    end
    if (nrst !== 1'b1) begin
      run = 0;
      bp_seen = 1'b0;
    end else begin
      cmp_lvl(bp_b, bp);
      if (bp !== bp_l) begin
        if (bp_seen) cmp_bp(run);
        bp_seen = 1'b1;
        run = 0;
      end
      run++;
    end
    bp_l = bp;
  end
  initial begin
    void'($urandom(64));
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    reset_peek();
    for (int k = 0; k < 16; k++) load(3'h1, {4'(15 - k), 4'(k)});
    load(3'h6, 8'h5A);
    repeat (10) load(3'($urandom_range(1, 7)), 8'($urandom));
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    reset_peek();
    load(3'h4, 8'($urandom));
    close_out();
  end
endmodule
